// >>> supervision_timer_pkg.sv
// Package with register map, field positions and timing constants of the supervision timer
package supervision_timer_pkg;
  // ****************************************
  // Register offsets on the plain register port
  // ****************************************
  localparam logic [1:0] CTRL_ADDR = 2'h0; // supervision_control_register
  localparam logic [1:0] CAUSE_ADDR = 2'h1; // reset_cause_register
  localparam logic [1:0] EVT_ADDR = 2'h2; // Event status, cleared by read
  localparam logic [1:0] MASK_ADDR = 2'h3; // Event mask

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_IRQ_FLAG = 7;
  localparam int CTRL_IRQ_EN = 6;
  localparam int CTRL_SEL_HI = 5;
  localparam int CTRL_UNLOCK = 4;
  localparam int CTRL_RST_EN = 3;
  localparam int CTRL_SEL_LO_MSB = 2;
  localparam int CAUSE_FLAG = 3;
  localparam int EVT_IRQ = 0;
  localparam int EVT_RST = 1;
  localparam int EVT_BITS = 2;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'h9; // Codes above are reserved
  localparam int OSC_FREQ_KHZ = 128; // Supervision oscillator rate
  localparam int SHORT_TIMEOUT_MS = 16;
  localparam int LONG_TIMEOUT_S = 8;
  localparam int BASE_TICKS = 2048; // Ticks selected by code 0
  localparam int CNT_W = 21;
  localparam int UNLOCK_CYCLES = 4; // Unlock window length in clk cycles
  localparam logic [2:0] UNLOCK_LOAD = 3'(UNLOCK_CYCLES);
endpackage

// >>> supervision_timer.sv
// Supervision timer with timed unlock, counting ticks of a separate slow oscillator
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module supervision_timer
  import supervision_timer_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W
) (
  input wire logic clk, // System clock, 40 MHz
  input wire logic reset, // Asynchronous reset, active high
  input wire logic oscClk, // Slow oscillator, asynchronous to clk
  input wire logic alwaysOnFuse, // Fuse level, forces reset mode
  input wire logic restartCmd, // One-cycle restart instruction pulse
  input wire logic vectorAck, // One-cycle pulse, interrupt vector executed
  input wire logic [1:0] addr, // Register address
  input wire logic [7:0] wdata, // Register write data
  input wire logic wrStb, // Write strobe
  input wire logic rdStb, // Read strobe
  output logic [7:0] rdata, // Read data, valid the cycle after rdStb
  output logic timeoutIrq, // Level interrupt request to the core
  output logic sysResetReq, // One-cycle system reset pulse
  output logic irq // Level event interrupt, status ANDed with mask
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [2:0] oscSync_ff;
  logic oscLvl_ff;
  logic tick;
  logic [CNT_WIDTH-1:0] cnt_ff;
  logic [CNT_WIDTH-1:0] limit;
  logic irqFlag_ff, irqEn_ff, rstEn_ff, causeFlag_ff;
  logic [3:0] sel_ff;
  logic [2:0] unlockCnt_ff;
  logic [EVT_BITS-1:0] evt_ff, mask_ff;
  logic [7:0] rdata_ff;
  logic running, expire, goReset, goIrq;
  logic rstEnEff, irqEnEff, windowOpen;
  logic ctrlWr, openWr, cfgWr, causeWr;

  // ****************************************
  // Oscillator synchroniser and tick detect
  // ****************************************
  // Three stages; a rising change counts once stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oscSync_ff <= 3'h0;
    end else begin
      oscSync_ff <= {oscSync_ff[1:0], oscClk};
    end
  end

  // Filtered level follows when the last two stages agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oscLvl_ff <= 1'b0;
    end else if (oscSync_ff[1] == oscSync_ff[2]) begin
      oscLvl_ff <= oscSync_ff[2];
    end
  end

  assign tick = (oscSync_ff[1] == oscSync_ff[2]) && oscSync_ff[2] && !oscLvl_ff;

  // ****************************************
  // Mode decode and period
  // ****************************************
  // Fuse overrides the stored enables
  assign rstEnEff = alwaysOnFuse | rstEn_ff;
  assign irqEnEff = !alwaysOnFuse & irqEn_ff;
  assign running = rstEnEff | irqEnEff;
  // Reserved codes fall back to the longest period
  assign limit = (sel_ff > SEL_MAX) ? (CNT_WIDTH'(BASE_TICKS) << SEL_MAX)
                                    : (CNT_WIDTH'(BASE_TICKS) << sel_ff);
  assign expire = running && tick && (cnt_ff == limit - CNT_WIDTH'(1));
  // Interrupt only when enabled and no interrupt still pending in combined mode
  assign goIrq = expire && irqEnEff && !(rstEnEff && irqFlag_ff);
  assign goReset = expire && rstEnEff && !goIrq;

  // ****************************************
  // Register port decode
  // ****************************************
  assign ctrlWr = wrStb && (addr == CTRL_ADDR);
  assign causeWr = wrStb && (addr == CAUSE_ADDR);
  assign windowOpen = (unlockCnt_ff != 3'h0);
  assign openWr = ctrlWr && wdata[CTRL_UNLOCK] && wdata[CTRL_RST_EN];
  assign cfgWr = ctrlWr && windowOpen && !wdata[CTRL_UNLOCK];

  // ****************************************
  // Tick counter
  // ****************************************
  // Restart on command, expiry or when stopped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= '0;
    end else if (restartCmd || !running || expire) begin
      cnt_ff <= '0;
    end else if (tick) begin
      cnt_ff <= cnt_ff + CNT_WIDTH'(1);
    end
  end

  // ****************************************
  // Unlock window
  // ****************************************
  // Counts down four cycles after the opening write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      unlockCnt_ff <= 3'h0;
    end else if (openWr) begin
      unlockCnt_ff <= UNLOCK_LOAD;
    end else if (cfgWr) begin
      unlockCnt_ff <= 3'h0;
    end else if (windowOpen) begin
      unlockCnt_ff <= unlockCnt_ff - 3'h1;
    end
  end

  // ****************************************
  // Control bits
  // ****************************************
  // Reset enable: set freely, cleared only inside window and with cause flag clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rstEn_ff <= 1'b0;
    end else if (causeFlag_ff || goReset) begin
      rstEn_ff <= 1'b1;
    end else if (cfgWr) begin
      rstEn_ff <= wdata[CTRL_RST_EN];
    end else if (ctrlWr && wdata[CTRL_RST_EN]) begin
      rstEn_ff <= 1'b1;
    end
  end

  // Period changes only inside the window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_ff <= SEL_RESET;
    end else if (cfgWr) begin
      sel_ff <= {wdata[CTRL_SEL_HI], wdata[CTRL_SEL_LO_MSB:0]};
    end
  end

  // Interrupt enable; vector execution drops it in combined mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqEn_ff <= 1'b0;
    end else if (vectorAck && rstEnEff && irqFlag_ff) begin
      irqEn_ff <= 1'b0;
    end else if (ctrlWr) begin
      irqEn_ff <= wdata[CTRL_IRQ_EN];
    end
  end

  // Interrupt flag: expiry wins over a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqFlag_ff <= 1'b0;
    end else if (goIrq) begin
      irqFlag_ff <= 1'b1;
    end else if (vectorAck || (ctrlWr && wdata[CTRL_IRQ_FLAG])) begin
      irqFlag_ff <= 1'b0;
    end
  end

  // Reset cause flag, cleared by writing zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      causeFlag_ff <= 1'b0;
    end else if (goReset) begin
      causeFlag_ff <= 1'b1;
    end else if (causeWr && !wdata[CAUSE_FLAG]) begin
      causeFlag_ff <= 1'b0;
    end
  end

  // ****************************************
  // Event status and mask
  // ****************************************
  // Sticky events, read clears, a new event wins over the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evt_ff <= '0;
    end else begin
      evt_ff <= ((rdStb && addr == EVT_ADDR) ? '0 : evt_ff)
                | {goReset, goIrq};
    end
  end

  // Event mask register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_ff <= '0;
    end else if (wrStb && addr == MASK_ADDR) begin
      mask_ff <= wdata[EVT_BITS-1:0];
    end
  end

  // ****************************************
  // Read data and outputs
  // ****************************************
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (rdStb) begin
      case (addr)
        CTRL_ADDR: rdata_ff <= {irqFlag_ff, irqEnEff, sel_ff[3], windowOpen, rstEnEff, sel_ff[2:0]};
        CAUSE_ADDR: rdata_ff <= 8'(causeFlag_ff) << CAUSE_FLAG;
        EVT_ADDR: rdata_ff <= 8'(evt_ff);
        MASK_ADDR: rdata_ff <= 8'(mask_ff);
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // Reset pulse register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sysResetReq <= 1'b0;
    end else begin
      sysResetReq <= goReset;
    end
  end

  assign rdata = rdata_ff;
  assign timeoutIrq = irqFlag_ff && irqEnEff;
  assign irq = |(evt_ff & mask_ff);
endmodule
`default_nettype wire

// >>> supervision_timer_sva.sv
// Port checker for the supervision timer
`timescale 1ns/1ps
`default_nettype none
module supervision_timer_chk
  import supervision_timer_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic restartCmd, // Restart
  input wire logic alwaysOnFuse, // Fuse
  input wire logic [1:0] addr, // Address
  input wire logic [7:0] wdata, // Data in
  input wire logic wrStb, // Write
  input wire logic rdStb, // Read
  input wire logic [7:0] rdata, // Data out
  input wire logic timeoutIrq, // Request
  input wire logic sysResetReq // Reset pulse
);
  // Control register accesses
  wire logic cw = wrStb && addr == CTRL_ADDR;
  wire logic cr = rdStb && addr == CTRL_ADDR;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  // Unlock steps
  sequence openWr; cw && wdata[CTRL_UNLOCK] && wdata[CTRL_RST_EN]; endsequence
  sequence closeWr; cw && !wdata[CTRL_UNLOCK]; endsequence
  // Port relations
  read_slot_a: assert property (rdata != 8'h00 |-> $past(rdStb))
    else $error("read data out of slot");
  reset_pulse_a: assert property (sysResetReq |=> !sysResetReq)
    else $error("reset pulse too long");
  fuse_lock_a: assert property ($past(alwaysOnFuse) && $past(cr) |-> rdata[3] && !rdata[6])
    else $error("fuse lock broken");
  unlock_open_a: assert property (openWr ##1 cr |=> rdata[CTRL_UNLOCK])
    else $error("unlock bit not set");
  late_clear_a: assert property (openWr ##1 !cw [*5] ##1 closeWr ##1 cr |=> rdata[3] && !rdata[4])
    else $error("late change taken");
  period_apply_a: assert property (openWr ##1 closeWr ##1 !cw [*4] ##1 cr |=>
    (rdata & 8'h27) == ($past(wdata, 6) & 8'h27))
    else $error("period not applied");
  irq_off_a: assert property (cw && !wdata[CTRL_IRQ_EN] |=> !timeoutIrq)
    else $error("request while disabled");
  restart_quiet_a: assert property (restartCmd |-> ##2 !sysResetReq [*8])
    else $error("reset soon after restart");
endmodule
bind supervision_timer supervision_timer_chk chk_u (.clk(clk), .reset(reset), .restartCmd(restartCmd),
  .alwaysOnFuse(alwaysOnFuse), .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
  .timeoutIrq(timeoutIrq), .sysResetReq(sysResetReq));
`default_nettype wire

// >>> core_model.sv
// Partner: core taking vectors, plus the slow oscillator
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk, // Clock
  input wire logic timeoutIrq, // Request
  input wire logic ackEn, // Vector allowed
  output logic oscClk, // Oscillator
  output logic vectorAck // Vector pulse
);
  // Free oscillator, 8 clocks per tick so expiries fit the run
  initial begin
    oscClk = 1'b0;
    #37 forever #100 oscClk = ~oscClk;
  end
  // Core executes the vector three cycles after a request
  initial begin
    vectorAck = 1'b0;
    forever begin
      @(posedge clk);
      if (ackEn && timeoutIrq === 1'b1) begin
        repeat (3) @(posedge clk);
        vectorAck <= 1'b1;
        @(posedge clk);
        vectorAck <= 1'b0;
        repeat (2) @(posedge clk);
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the supervision timer
`timescale 1ns/1ps
`default_nettype none
module tb
  import supervision_timer_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, fuse = 1'b0, restartCmd = 1'b0, wrStb = 1'b0, rdStb = 1'b0, ackEn = 1'b0;
  logic rdPend = 1'b0, timeoutIrq, sysResetReq, irq, oscClk, vectorAck;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, cb;
  logic [3:0] code;
  logic [7:0] expQ[$];
  int failures = 0, check_count = 0, n, gap;
  supervision_timer dut_u (.clk(clk), .reset(reset), .oscClk(oscClk), .alwaysOnFuse(fuse), .restartCmd(restartCmd),
    .vectorAck(vectorAck), .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
    .timeoutIrq(timeoutIrq), .sysResetReq(sysResetReq), .irq(irq));
  core_model core_u (.clk(clk), .timeoutIrq(timeoutIrq), .ackEn(ackEn), .oscClk(oscClk), .vectorAck(vectorAck));
  // Clock, 40 MHz
  always #12.5 clk = ~clk;
  // Compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One bus cycle; a read notes its expected data
  task acc(input logic w, input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wrStb <= w;
    rdStb <= !w;
    if (!w) expQ.push_back(d);
    @(posedge clk);
  endtask
  task idle(input int k);
    wrStb <= 1'b0;
    rdStb <= 1'b0;
    repeat (k) @(posedge clk);
  endtask
  task restart;
    restartCmd <= 1'b1;
    idle(1);
    restartCmd <= 1'b0;
  endtask
  // Bounded wait for an expiry action, cycles in n
  task waitEv(input logic rstAct);
    idle(0);
    for (n = 1; n < 40000; n++) begin
      @(posedge clk);
      if ((rstAct ? sysResetReq : timeoutIrq) === 1'b1) break;
    end
    if (n == 40000) begin
      failures++;
      final_report();
    end
  endtask
  // Read data watcher, takes the oldest note
  always @(posedge clk) begin
    if (rdPend) chk(rdata, expQ.pop_front());
    rdPend <= rdStb;
  end
  // Main sequence
  initial begin
    void'($urandom(96352));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    acc(0, CTRL_ADDR, 8'h00);
    acc(0, CAUSE_ADDR, 8'h00);
    $display("reset values done");
    acc(1, MASK_ADDR, 8'h03);
    acc(1, CTRL_ADDR, 8'h40);
    waitEv(0);
    chk({7'h0, irq}, 8'h01);
    acc(0, CTRL_ADDR, 8'hC0);
    acc(0, EVT_ADDR, 8'h01);
    acc(0, EVT_ADDR, 8'h00);
    chk({7'h0, irq}, 8'h00);
    acc(1, CTRL_ADDR, 8'hC0);
    waitEv(0);
    chk(8'(n > 16300 && n < 16420), 8'h01);
    acc(1, CTRL_ADDR, 8'h80);
    $display("interrupt mode done");
    acc(1, CTRL_ADDR, 8'h08);
    acc(1, CTRL_ADDR, 8'h00);
    acc(0, CTRL_ADDR, 8'h08);
    restart();
    acc(1, CTRL_ADDR, 8'h18);
    acc(0, CTRL_ADDR, 8'h18);
    idle(4);
    acc(1, CTRL_ADDR, 8'h00);
    acc(0, CTRL_ADDR, 8'h08);
    code = 4'($urandom_range(9, 0));
    gap = $urandom_range(3, 0);
    cb = {2'h0, code[3], 2'h0, code[2:0]};
    acc(1, CTRL_ADDR, 8'h18);
    idle(gap);
    acc(1, CTRL_ADDR, cb);
    idle(4);
    acc(0, CTRL_ADDR, cb);
    acc(1, CTRL_ADDR, cb | 8'h18);
    acc(1, CTRL_ADDR, 8'h08);
    idle(4);
    acc(0, CTRL_ADDR, 8'h08);
    $display("unlock done");
    restart();
    waitEv(1);
    acc(1, MASK_ADDR, 8'h00);
    idle(1);
    chk({7'h0, irq}, 8'h00);
    acc(0, CAUSE_ADDR, 8'h08);
    acc(0, EVT_ADDR, 8'h03);
    acc(1, CTRL_ADDR, 8'h18);
    acc(1, CTRL_ADDR, 8'h00);
    idle(4);
    acc(0, CTRL_ADDR, 8'h08);
    $display("reset mode done");
    ackEn <= 1'b1;
    restart();
    acc(1, CTRL_ADDR, 8'h48);
    waitEv(0);
    idle(8);
    acc(0, CTRL_ADDR, 8'h08);
    waitEv(1);
    acc(0, EVT_ADDR, 8'h03);
    $display("combined mode done");
    acc(1, CAUSE_ADDR, 8'h00);
    acc(1, CTRL_ADDR, 8'h18);
    acc(1, CTRL_ADDR, 8'h40);
    fuse <= 1'b1;
    idle(4);
    acc(0, CTRL_ADDR, 8'h08);
    idle(2);
    $display("fuse done");
    final_report();
  end
endmodule
`default_nettype wire
